// ---- include/utr_pkg.sv ----
// Purpose: shared constants and types for the serial port core
// Assumes: 32-bit AXI4-Lite register access, single clock
// Notes:   control and status layouts are the packed structs below, bit 0 last
package utr_pkg;
	localparam logic [7:0]  STATUS_OFS  = 8'h00;
	localparam logic [7:0]  CTRL_OFS    = 8'h04;
	localparam logic [7:0]  DATA_OFS    = 8'h08;
	localparam logic [7:0]  COUNT_OFS   = 8'h0c;
	localparam logic [7:0]  DIV_OFS     = 8'h10;
	localparam logic [11:0] CTRL_RST    = 12'h000;
	localparam logic [15:0] DIV_RST     = 16'h0000;
	localparam int          FIFO_DEPTH  = 4;
	localparam logic [3:0]  SUB_LAST    = 4'hf;
	localparam logic [3:0]  SAMPLE_AT   = 4'h7;
	localparam logic [3:0]  BREAK_ZEROS = 4'hd;
	localparam logic [3:0]  TX_RX_STOP_COUNT_SEL    = 4'h2;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [1:0]  PAR_EVEN    = 2'h0;
	localparam logic [1:0]  PAR_ODD     = 2'h1;
	localparam logic [1:0]  PAR_MARK    = 2'h2;

	typedef struct packed {
		logic [1:0] trig;
		logic       rx_irq_enable;
		logic       tx_empty_irq_enable;
		logic       tx9;
		logic       brk;
		logic       rx_en;
		logic       stop2;
		logic [1:0] par_type;
		logic       par_en;
		logic       word9;
	} utr_cfg_t;

	typedef struct packed {
		logic pe;
		logic nf;
		logic fe;
		logic ovr;
		logic rx_idle_flag;
		logic rxav;
		logic tx_idle_flag;
		logic tbe;
	} utr_stat_t;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_DATA = 2'b01,
		TX_STOP = 2'b10,
		TX_BRK  = 2'b11
	} utr_tx_st_t;

	typedef enum logic [2:0] {
		RX_IDLE   = 3'b000,
		RX_START  = 3'b001,
		RX_BITS   = 3'b010,
		RX_STOP   = 3'b011,
		RX_WAITHI = 3'b100
	} utr_rx_st_t;
endpackage

// ---- design/utr_rx_sampler.sv ----
// Purpose: receive pin synchroniser and three-sample majority vote
// Assumes: tick is the 16x oversampling enable pulse
// Notes:   vote and noise are valid in the cycle that valid is high
module utr_rx_sampler (
	// Clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// Line and rate
	input  wire logic rx_pin,
	input  wire logic tick,
	// Decision
	output logic      valid,
	output logic      vote,
	output logic      noise
);
	logic [2:0] sync_r, sync_nxt;
	logic       stable_r, stable_nxt;
	logic [2:0] hist_r, hist_nxt;
	logic       valid_nxt, vote_nxt, noise_nxt;

	always_comb
	begin
		sync_nxt   = {sync_r[1:0], rx_pin};
		// A level counts only once the last two stages agree
		stable_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : stable_r;
		hist_nxt   = tick ? {hist_r[1:0], stable_r} : hist_r;
		valid_nxt  = tick;
		vote_nxt   = (hist_nxt[0] & hist_nxt[1]) | (hist_nxt[0] & hist_nxt[2])
			| (hist_nxt[1] & hist_nxt[2]);
		noise_nxt  = !((&hist_nxt) | ~(|hist_nxt));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_r   <= 3'h7;
			stable_r <= 1'b1;
			hist_r   <= 3'h7;
			valid    <= 1'b0;
			vote     <= 1'b1;
			noise    <= 1'b0;
		end
		else
		begin
			sync_r   <= sync_nxt;
			stable_r <= stable_nxt;
			hist_r   <= hist_nxt;
			valid    <= valid_nxt;
			vote     <= vote_nxt;
			noise    <= noise_nxt;
		end
	end
endmodule

// ---- design/utr_core.sv ----
// Purpose: asynchronous serial port transmit and receive core with AXI4-Lite registers
// Assumes: one clock; baud divisor gives the 16x rate
// Notes:   status flags are read only and clear through access sequences
module utr_core #(
	parameter int FIFO_DEPTH = utr_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Serial line and interrupt
	input  wire logic        rx_pin,
	output logic             tx_pin,
	output logic             irq
);
	localparam int PW = $clog2(FIFO_DEPTH);

	generate
		if (FIFO_DEPTH != 4 && FIFO_DEPTH != 8)
			$error("FIFO_DEPTH must be 4 or 8");
	endgenerate

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	utr_pkg::utr_cfg_t   cfg_r, cfg_nxt;
	utr_pkg::utr_stat_t  stat;
	utr_pkg::utr_tx_st_t tx_st_r, tx_st_nxt;
	utr_pkg::utr_rx_st_t rx_st_r, rx_st_nxt;
	logic [15:0] div_r, div_nxt, div_cnt_r, div_cnt_nxt;
	logic [16:0] brk_cnt_r, brk_cnt_nxt;
	logic        tick_r, tick_nxt, brk_armed, bit_end;
	logic        aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
	logic [7:0]  aw_addr_r, aw_addr_nxt;
	logic [31:0] w_data_r, w_data_nxt, wm_c, wm_d;
	logic [3:0]  w_strb_r, w_strb_nxt;
	logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
	logic [1:0]  bresp_nxt, rresp_nxt;
	logic [31:0] rdata_nxt;
	logic        seq_r, seq_nxt, wr_go, rd_go, tx_wr, data_rd, pop, rx_clr;
	logic [9:0]  tx_sh_r, tx_sh_nxt;
	logic [3:0]  tx_bits_r, tx_bits_nxt, tx_sub_r, tx_sub_nxt;
	logic [8:0]  tx_buf_r, tx_buf_nxt, load_val;
	logic        tx_full_r, tx_full_nxt, tbe_r, tbe_nxt, tx_idle_flag_r, tx_idle_flag_nxt;
	logic        txd_nxt, frame_end, load;
	logic        samp_v, vote, noise, mid, last, push, accept;
	logic [8:0]  rx_sh_r, rx_sh_nxt, rx_word;
	logic [3:0]  rx_bits_r, rx_bits_nxt, rx_sub_r, rx_sub_nxt;
	logic        rx_idle_flag_r, rx_idle_flag_nxt, fe_acc_r, fe_acc_nxt, nz_acc_r, nz_acc_nxt;
	logic        ovr_r, ovr_nxt, fe_r, fe_nxt, nf_r, nf_nxt, pe_r, pe_nxt, irq_nxt;
	logic        push_fe, push_pe;
	logic [8:0]  mem [FIFO_DEPTH];
	logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
	logic [PW:0]   cnt_r, cnt_nxt;

	function automatic logic par_bit(input logic [7:0] d, input logic [1:0] t);
		case (t)
			utr_pkg::PAR_EVEN: return ^d;
			utr_pkg::PAR_ODD:  return ~^d;
			utr_pkg::PAR_MARK: return 1'b1;
			default:           return 1'b0;
		endcase
	endfunction

	// Parity replaces the top payload bit, as in the 7+P and 8+P formats
	function automatic logic [8:0] add_par(input logic [8:0] d, input utr_pkg::utr_cfg_t c);
		logic [8:0] p;
		p = c.word9 ? d : {1'b0, d[7:0]};
		if (c.par_en && c.word9)
			p[8] = par_bit(d[7:0], c.par_type);
		else if (c.par_en)
			p[7] = par_bit({1'b0, d[6:0]}, c.par_type);
		return p;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (s[i]) r[8*i +: 8] = n[8*i +: 8];
		return r;
	endfunction

	assign wr_go   = aw_have_r && w_have_r && !s_axi_bvalid;
	assign rd_go   = s_axi_arvalid && s_axi_arready;
	assign tx_wr   = wr_go && aw_addr_r == utr_pkg::DATA_OFS && w_strb_r[0];
	assign data_rd = rd_go && s_axi_araddr == utr_pkg::DATA_OFS;
	assign pop     = data_rd && cnt_r != '0;
	assign rx_clr  = data_rd && seq_r;
	assign wm_c    = merge({20'h0, cfg_r}, w_data_r, w_strb_r);
	assign wm_d    = merge({16'h0, div_r}, w_data_r, w_strb_r);
	assign stat    = '{pe: pe_r, nf: nf_r, fe: fe_r, ovr: ovr_r, rx_idle_flag: rx_idle_flag_r,
		rxav: cnt_r != '0, tx_idle_flag: tx_idle_flag_r, tbe: tbe_r};

	// Register bus; one write and one read in flight at most
	always_comb
	begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt  = w_have_r;
		w_data_nxt  = w_data_r;
		w_strb_nxt  = w_strb_r;
		cfg_nxt     = cfg_r;
		div_nxt     = div_r;
		seq_nxt     = seq_r;
		bvalid_nxt  = s_axi_bvalid && !s_axi_bready;
		bresp_nxt   = s_axi_bresp;
		rvalid_nxt  = s_axi_rvalid && !s_axi_rready;
		rdata_nxt   = s_axi_rdata;
		rresp_nxt   = s_axi_rresp;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_nxt = 1'b1;
			w_data_nxt = s_axi_wdata;
			w_strb_nxt = s_axi_wstrb;
		end
		if (wr_go)
		begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = utr_pkg::RESP_OKAY;
			case (aw_addr_r)
				utr_pkg::CTRL_OFS:   cfg_nxt = utr_pkg::utr_cfg_t'(wm_c[11:0]);
				utr_pkg::DIV_OFS:    div_nxt = wm_d[15:0];
				utr_pkg::DATA_OFS:   seq_nxt = 1'b0;
				utr_pkg::STATUS_OFS: ;
				utr_pkg::COUNT_OFS:  ;
				default:             bresp_nxt = utr_pkg::RESP_SLVERR;
			endcase
		end
		if (rd_go)
		begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = utr_pkg::RESP_OKAY;
			case (s_axi_araddr)
				utr_pkg::STATUS_OFS:
				begin
					rdata_nxt = {24'h0, stat};
					seq_nxt   = 1'b1;
				end
				utr_pkg::CTRL_OFS:  rdata_nxt = {20'h0, cfg_r};
				utr_pkg::DATA_OFS:
				begin
					rdata_nxt = {23'h0, mem[rp_r]};
					seq_nxt   = 1'b0;
				end
				utr_pkg::COUNT_OFS: rdata_nxt = {{(31 - PW){1'b0}}, cnt_r};
				utr_pkg::DIV_OFS:   rdata_nxt = {16'h0, div_r};
				default:
				begin
					rdata_nxt = 32'h0;
					rresp_nxt = utr_pkg::RESP_SLVERR;
				end
			endcase
		end
		awready_nxt = !aw_have_nxt;
		wready_nxt  = !w_have_nxt;
		arready_nxt = !rvalid_nxt;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_r     <= 1'b0;
			aw_addr_r     <= 8'h00;
			w_have_r      <= 1'b0;
			w_data_r      <= 32'h0;
			w_strb_r      <= 4'h0;
			cfg_r         <= utr_pkg::CTRL_RST;
			div_r         <= utr_pkg::DIV_RST;
			seq_r         <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= utr_pkg::RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0;
			s_axi_rresp   <= utr_pkg::RESP_OKAY;
		end
		else
		begin
			aw_have_r     <= aw_have_nxt;
			aw_addr_r     <= aw_addr_nxt;
			w_have_r      <= w_have_nxt;
			w_data_r      <= w_data_nxt;
			w_strb_r      <= w_strb_nxt;
			cfg_r         <= cfg_nxt;
			div_r         <= div_nxt;
			seq_r         <= seq_nxt;
			s_axi_awready <= awready_nxt;
			s_axi_wready  <= wready_nxt;
			s_axi_bvalid  <= bvalid_nxt;
			s_axi_bresp   <= bresp_nxt;
			s_axi_arready <= arready_nxt;
			s_axi_rvalid  <= rvalid_nxt;
			s_axi_rdata   <= rdata_nxt;
			s_axi_rresp   <= rresp_nxt;
		end
	end

	assign brk_armed = brk_cnt_r > ({1'b0, div_r} + 17'h1);
	assign bit_end   = tick_r && tx_sub_r == utr_pkg::SUB_LAST;

	// Transmitter and baud divider
	always_comb
	begin
		div_cnt_nxt = div_cnt_r + 16'h1;
		tick_nxt    = 1'b0;
		if (div_cnt_r >= div_r)
		begin
			div_cnt_nxt = 16'h0;
			tick_nxt    = 1'b1;
		end
		brk_cnt_nxt = brk_cnt_r;
		if (!cfg_r.brk || tx_st_r != utr_pkg::TX_IDLE)
			brk_cnt_nxt = 17'h0;
		else if (!brk_armed)
			brk_cnt_nxt = brk_cnt_r + 17'h1;
		tx_st_nxt   = tx_st_r;
		tx_sh_nxt   = tx_sh_r;
		tx_bits_nxt = tx_bits_r;
		tx_sub_nxt  = (tx_st_r != utr_pkg::TX_IDLE && tick_r) ? tx_sub_r + 4'h1 : tx_sub_r;
		tx_buf_nxt  = tx_buf_r;
		tx_full_nxt = tx_full_r;
		tbe_nxt     = tbe_r;
		tx_idle_flag_nxt   = tx_idle_flag_r;
		txd_nxt     = tx_pin;
		frame_end   = 1'b0;
		load        = 1'b0;
		load_val    = tx_buf_r;
		case (tx_st_r)
			utr_pkg::TX_DATA:
				if (bit_end && tx_bits_r != 4'h0)
				begin
					tx_sh_nxt   = {1'b1, tx_sh_r[9:1]};
					txd_nxt     = tx_sh_r[1];
					tx_bits_nxt = tx_bits_r - 4'h1;
				end
				else if (bit_end)
				begin
					tx_st_nxt   = utr_pkg::TX_STOP;
					tx_bits_nxt = utr_pkg::TX_RX_STOP_COUNT_SEL - 4'h1;
					txd_nxt     = 1'b1;
				end
			utr_pkg::TX_BRK:
				if (bit_end && tx_bits_r != 4'h0)
					tx_bits_nxt = tx_bits_r - 4'h1;
				else if (bit_end && cfg_r.brk)
					tx_bits_nxt = utr_pkg::BREAK_ZEROS;
				else if (bit_end)
				begin
					tx_st_nxt   = utr_pkg::TX_STOP;
					tx_bits_nxt = utr_pkg::TX_RX_STOP_COUNT_SEL - 4'h1;
					txd_nxt     = 1'b1;
				end
			utr_pkg::TX_STOP:
				if (bit_end && tx_bits_r != 4'h0)
					tx_bits_nxt = tx_bits_r - 4'h1;
				else if (bit_end)
				begin
					frame_end = 1'b1;
					tx_st_nxt = utr_pkg::TX_IDLE;
				end
			default: ;
		endcase
		if (tx_st_nxt == utr_pkg::TX_IDLE)
		begin
			if (tx_full_r)
			begin
				load        = 1'b1;
				tx_full_nxt = 1'b0;
				tbe_nxt     = 1'b1;
			end
			else if (tx_wr && tbe_r)
			begin
				load      = 1'b1;
				load_val  = {cfg_r.tx9, w_data_r[7:0]};
				tx_idle_flag_nxt = 1'b0;
			end
			else if (brk_armed)
			begin
				tx_st_nxt   = utr_pkg::TX_BRK;
				tx_bits_nxt = utr_pkg::BREAK_ZEROS;
				tx_sub_nxt  = 4'h0;
				txd_nxt     = 1'b0;
				tx_idle_flag_nxt   = 1'b0;
			end
			else if (frame_end)
				tx_idle_flag_nxt = 1'b1;
		end
		else if (tx_wr && tbe_r)
		begin
			tx_buf_nxt  = {cfg_r.tx9, w_data_r[7:0]};
			tx_full_nxt = 1'b1;
			tbe_nxt     = 1'b0;
			tx_idle_flag_nxt   = 1'b0;
		end
		if (load)
		begin
			tx_st_nxt   = utr_pkg::TX_DATA;
			tx_sh_nxt   = {add_par(load_val, cfg_r), 1'b0};
			tx_bits_nxt = cfg_r.word9 ? 4'h9 : 4'h8;
			tx_sub_nxt  = 4'h0;
			txd_nxt     = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			div_cnt_r <= 16'h0;
			tick_r    <= 1'b0;
			brk_cnt_r <= 17'h0;
			tx_st_r   <= utr_pkg::TX_IDLE;
			tx_sh_r   <= 10'h3ff;
			tx_bits_r <= 4'h0;
			tx_sub_r  <= 4'h0;
			tx_buf_r  <= 9'h000;
			tx_full_r <= 1'b0;
			tbe_r     <= 1'b1;
			tx_idle_flag_r   <= 1'b1;
			tx_pin    <= 1'b1;
		end
		else
		begin
			div_cnt_r <= div_cnt_nxt;
			tick_r    <= tick_nxt;
			brk_cnt_r <= brk_cnt_nxt;
			tx_st_r   <= tx_st_nxt;
			tx_sh_r   <= tx_sh_nxt;
			tx_bits_r <= tx_bits_nxt;
			tx_sub_r  <= tx_sub_nxt;
			tx_buf_r  <= tx_buf_nxt;
			tx_full_r <= tx_full_nxt;
			tbe_r     <= tbe_nxt;
			tx_idle_flag_r   <= tx_idle_flag_nxt;
			tx_pin    <= txd_nxt;
		end
	end

	utr_rx_sampler u_samp (
		.aclk    (aclk),
		.aresetn (aresetn),
		.rx_pin  (rx_pin),
		.tick    (tick_r),
		.valid   (samp_v),
		.vote    (vote),
		.noise   (noise)
	);

	assign mid     = samp_v && rx_sub_r == utr_pkg::SAMPLE_AT;
	assign last    = samp_v && rx_sub_r == utr_pkg::SUB_LAST;
	assign rx_word = cfg_r.word9 ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
	assign push_fe = fe_acc_r || !vote;
	assign push_pe = cfg_r.par_en && (cfg_r.word9
		? rx_word[8] != par_bit(rx_word[7:0], cfg_r.par_type)
		: rx_word[7] != par_bit({1'b0, rx_word[6:0]}, cfg_r.par_type));
	assign accept  = push && (cnt_r != FIFO_DEPTH[PW:0] || pop);

	// Receiver, FIFO and flags
	always_comb
	begin
		rx_st_nxt   = rx_st_r;
		rx_sh_nxt   = rx_sh_r;
		rx_bits_nxt = rx_bits_r;
		rx_sub_nxt  = samp_v ? rx_sub_r + 4'h1 : rx_sub_r;
		rx_idle_flag_nxt   = rx_idle_flag_r;
		fe_acc_nxt  = fe_acc_r;
		nz_acc_nxt  = nz_acc_r | (mid & noise);
		push        = 1'b0;
		case (rx_st_r)
			utr_pkg::RX_IDLE:
				if (samp_v && !vote)
				begin
					rx_st_nxt  = utr_pkg::RX_START;
					rx_sub_nxt = 4'h0;
					rx_idle_flag_nxt  = 1'b0;
					fe_acc_nxt = 1'b0;
					nz_acc_nxt = 1'b0;
				end
			utr_pkg::RX_START:
				if (mid && vote)
				begin
					rx_st_nxt = utr_pkg::RX_IDLE;
					rx_idle_flag_nxt = 1'b1;
				end
				else if (last)
				begin
					rx_st_nxt   = utr_pkg::RX_BITS;
					rx_bits_nxt = cfg_r.word9 ? 4'h8 : 4'h7;
				end
			utr_pkg::RX_BITS:
			begin
				if (mid)
					rx_sh_nxt = {vote, rx_sh_r[8:1]};
				if (last && rx_bits_r != 4'h0)
					rx_bits_nxt = rx_bits_r - 4'h1;
				else if (last)
				begin
					rx_st_nxt   = utr_pkg::RX_STOP;
					rx_bits_nxt = cfg_r.stop2 ? 4'h1 : 4'h0;
				end
			end
			utr_pkg::RX_STOP:
			begin
				if (mid && !vote)
					fe_acc_nxt = 1'b1;
				if (mid && rx_bits_r == 4'h0)
				begin
					push      = 1'b1;
					rx_idle_flag_nxt = 1'b1;
					// no start from a low line
					rx_st_nxt = push_fe ? utr_pkg::RX_WAITHI : utr_pkg::RX_IDLE;
				end
				else if (last)
					rx_bits_nxt = rx_bits_r - 4'h1;
			end
			utr_pkg::RX_WAITHI:
				if (samp_v && vote)
					rx_st_nxt = utr_pkg::RX_IDLE;
			default: rx_st_nxt = utr_pkg::RX_IDLE;
		endcase
		if (!cfg_r.rx_en)
		begin
			rx_st_nxt = utr_pkg::RX_IDLE;
			rx_idle_flag_nxt = 1'b1;
			push      = 1'b0;
		end
		wp_nxt  = accept ? wp_r + 1'b1 : wp_r;
		rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
		cnt_nxt = cnt_r + {{PW{1'b0}}, accept} - {{PW{1'b0}}, pop};
		// Sequence clears first so a same-cycle event still lands
		ovr_nxt = ovr_r & !rx_clr;
		fe_nxt  = fe_r & !rx_clr;
		nf_nxt  = nf_r & !rx_clr;
		pe_nxt  = pe_r & !rx_clr;
		if (push && !accept)
			ovr_nxt = 1'b1;
		if (accept)
		begin
			fe_nxt = fe_nxt | push_fe;
			nf_nxt = nf_nxt | nz_acc_r | noise;
			pe_nxt = pe_nxt | push_pe;
		end
		irq_nxt = (cfg_r.tx_empty_irq_enable & tbe_r)
			| (cfg_r.rx_irq_enable & (ovr_r | cnt_r >= ({{(PW - 1){1'b0}}, cfg_r.trig} + 1'b1)));
	end

	always_ff @(posedge aclk)
	begin
		if (accept)
			mem[wp_r] <= rx_word;
		if (!aresetn)
		begin
			rx_st_r   <= utr_pkg::RX_IDLE;
			rx_sh_r   <= 9'h000;
			rx_bits_r <= 4'h0;
			rx_sub_r  <= 4'h0;
			rx_idle_flag_r   <= 1'b1;
			fe_acc_r  <= 1'b0;
			nz_acc_r  <= 1'b0;
			wp_r      <= '0;
			rp_r      <= '0;
			cnt_r     <= '0;
			ovr_r     <= 1'b0;
			fe_r      <= 1'b0;
			nf_r      <= 1'b0;
			pe_r      <= 1'b0;
			irq       <= 1'b0;
		end
		else
		begin
			rx_st_r   <= rx_st_nxt;
			rx_sh_r   <= rx_sh_nxt;
			rx_bits_r <= rx_bits_nxt;
			rx_sub_r  <= rx_sub_nxt;
			rx_idle_flag_r   <= rx_idle_flag_nxt;
			fe_acc_r  <= fe_acc_nxt;
			nz_acc_r  <= nz_acc_nxt;
			wp_r      <= wp_nxt;
			rp_r      <= rp_nxt;
			cnt_r     <= cnt_nxt;
			ovr_r     <= ovr_nxt;
			fe_r      <= fe_nxt;
			nf_r      <= nf_nxt;
			pe_r      <= pe_nxt;
			irq       <= irq_nxt;
		end
	end

	direct_load_a: assert property (
		tx_st_r == utr_pkg::TX_IDLE && !tx_full_r && tx_wr && tbe_r
		|=> tbe_r && tx_st_r == utr_pkg::TX_DATA && !tx_pin)
		else $error("idle write did not start frame");
	buf_wait_a: assert property (
		tx_full_r && !frame_end |=> tx_full_r && !tbe_r)
		else $error("buffered word left early");
	idle_set_a: assert property (
		frame_end && !tx_full_r && !tx_wr && !brk_armed |=> tx_idle_flag_r)
		else $error("transmit idle not set after frame");
	line_high_a: assert property (
		tx_st_r == utr_pkg::TX_IDLE || tx_st_r == utr_pkg::TX_STOP |-> tx_pin)
		else $error("line low outside data");
	brk_low_a: assert property (
		tx_st_r == utr_pkg::TX_BRK |-> !tx_pin && $stable(tbe_r))
		else $error("break bit high or flag moved");
	brk_end_a: assert property (
		tx_st_r == utr_pkg::TX_BRK && bit_end && tx_bits_r == 4'h0 && !cfg_r.brk
		|=> tx_st_r == utr_pkg::TX_STOP && tx_pin)
		else $error("no stop after break");
	ovr_drop_a: assert property (
		push && cnt_r == FIFO_DEPTH[PW:0] && !pop |=> ovr_r && $stable(cnt_r))
		else $error("overrun not flagged");
	fifo_inc_a: assert property (
		push && cnt_r == '0 |=> stat.rxav && cnt_r == 1)
		else $error("data available not raised");
	rx_busy_a: assert property (
		rx_st_r == utr_pkg::RX_BITS |-> !rx_idle_flag_r)
		else $error("receive idle high mid frame");
endmodule

// ---- bench/utr_partner.sv ----
// Purpose: remote serial device facing the port core
// Assumes: fixed bit time in aclk cycles, line idles high
// Notes:   seen holds {stop2, stop1, byte} of each captured frame
module utr_partner #(
	parameter int BIT = 16
) (
	// Clock
	input  wire logic aclk,
	// Line
	input  wire logic tx_pin,
	output logic      rx_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [9:0] seen [8];
	int         n_seen = 0;
	initial
		rx_pin = 1'h1;
	// The stop bit, then one high bit time, end each frame
	task automatic send(input logic [7:0] v, input logic stop);
		for (int i = 0; i < 11; i++)
		begin
			rx_pin <= (i == 0) ? 1'h0 : (i == 9) ? stop : (i == 10) ? 1'h1 : v[i-1];
			repeat (BIT) @(posedge aclk);
		end
	endtask
	// Mid-bit sampling of the transmit line
	initial
		forever
		begin
			@(negedge tx_pin);
			repeat (BIT / 2) @(posedge aclk);
			for (int i = 0; i < 10; i++)
			begin
				repeat (BIT) @(posedge aclk);
				seen[n_seen][i] = tx_pin;
			end
			n_seen++;
		end
endmodule

// ---- bench/tb.sv ----
// Purpose: self-checking bench for the serial port core
// Assumes: divisor 0, so a bit lasts 16 aclk cycles
// Notes:   ready lines held high, so answers are taken at once
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'h0, aresetn = 1'h0, awv = 1'h0, wv = 1'h0, arv = 1'h0;
	logic        awr, wrr, bv, arr, rv, tx_pin, rx_pin, irq;
	logic [7:0]  awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, rdat, d;
	logic [1:0]  br, rr, r;
	int          failures = 0, num_checks = 0, n, k;
	utr_core i_utr_core (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
		.s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wv), .s_axi_wready(wrr), .s_axi_bresp(br), .s_axi_bvalid(bv),
		.s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
		.s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(1'h1),
		.rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
	utr_partner #(.BIT(16)) i_utr_partner (.aclk(aclk), .tx_pin(tx_pin), .rx_pin(rx_pin));
	initial
		forever
			#50 aclk = ~aclk;
	task automatic stop_test();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// A wait that runs out ends the run
	task automatic lim(input int c, input int m);
		if (c >= m)
		begin
			failures++;
			$display("[ERR] %0t wait ran out", $time);
			stop_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		awa <= a;
		wd <= v;
		awv <= 1'h1;
		wv <= 1'h1;
		for (n = 0; n < 60; n++)
		begin
			@(posedge aclk);
			if (awr === 1'h1)
				awv <= 1'h0;
			if (wrr === 1'h1)
				wv <= 1'h0;
			if (bv === 1'h1)
				break;
		end
		r = br;
		lim(n, 60);
	endtask
	task automatic rd(input logic [7:0] a);
		ara <= a;
		arv <= 1'h1;
		for (n = 0; n < 60; n++)
		begin
			@(posedge aclk);
			if (arr === 1'h1)
				arv <= 1'h0;
			if (rv === 1'h1)
				break;
		end
		d = rdat;
		r = rr;
		lim(n, 60);
	endtask
	task automatic poll(input logic [31:0] m);
		int j;
		for (j = 0; j < 400; j++)
		begin
			rd(utr_pkg::STATUS_OFS);
			if ((d & m) === m)
				break;
		end
		lim(j, 400);
	endtask
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(utr_pkg::STATUS_OFS);
		chk(d, 32'h0000000b);
		rd(8'h20);
		chk(32'(r), 32'(utr_pkg::RESP_SLVERR));
		wr(8'h20, 32'h0);
		chk(32'(r), 32'(utr_pkg::RESP_SLVERR));
		wr(utr_pkg::DATA_OFS, 32'h55);
		chk(32'(r), 32'(utr_pkg::RESP_OKAY));
		rd(utr_pkg::STATUS_OFS);
		chk(32'(d[1:0]), 32'h1);
		wr(utr_pkg::DATA_OFS, 32'ha3);
		rd(utr_pkg::STATUS_OFS);
		chk(32'(d[1:0]), 32'h0);
		poll(32'h2);
		chk(32'(i_utr_partner.seen[0]), 32'h355);
		chk(32'(i_utr_partner.seen[1]), 32'h3a3);
		chk(32'(tx_pin), 32'h1);
		wr(utr_pkg::CTRL_OFS, 32'h620);
		i_utr_partner.send(8'h11, 1'h1);
		chk(32'(irq), 32'h0);
		i_utr_partner.send(8'h22, 1'h1);
		chk(32'(irq), 32'h1);
		for (k = 3; k < 6; k++)
			i_utr_partner.send(8'(8'h11 * k), 1'h1);
		rd(utr_pkg::COUNT_OFS);
		chk(d, 32'h4);
		rd(utr_pkg::STATUS_OFS);
		chk(32'(d[4:0]), 32'h1f);
		for (k = 1; k < 5; k++)
		begin
			rd(utr_pkg::DATA_OFS);
			chk(32'(d[8:0]), 32'(8'h11 * k));
		end
		rd(utr_pkg::STATUS_OFS);
		chk(32'(d[4:2]), 32'h2);
		wr(utr_pkg::CTRL_OFS, 32'h21);
		i_utr_partner.send(8'h5a, 1'h1);
		rd(utr_pkg::DATA_OFS);
		chk(32'(d[8:0]), 32'h15a);
		wr(utr_pkg::CTRL_OFS, 32'h20);
		i_utr_partner.send(8'h00, 1'h0);
		rd(utr_pkg::STATUS_OFS);
		chk(32'(d[5:2]), 32'hb);
		rd(utr_pkg::DATA_OFS);
		chk(32'(d[8:0]), 32'h0);
		i_utr_partner.send(8'h3c, 1'h1);
		rd(utr_pkg::DATA_OFS);
		chk(32'(d[8:0]), 32'h3c);
		wr(utr_pkg::CTRL_OFS, 32'h22);
		wr(utr_pkg::DATA_OFS, 32'h01);
		i_utr_partner.send(8'h01, 1'h1);
		rd(utr_pkg::STATUS_OFS);
		chk(32'(d[7:5]), 32'h4);
		rd(utr_pkg::DATA_OFS);
		chk(32'(d[8:0]), 32'h1);
		poll(32'h2);
		chk(32'(i_utr_partner.seen[2]), 32'h381);
		wr(utr_pkg::CTRL_OFS, 32'h30);
		i_utr_partner.send(8'h12, 1'h0);
		rd(utr_pkg::STATUS_OFS);
		chk(32'(d[7:5]), 32'h1);
		rd(utr_pkg::DATA_OFS);
		chk(32'(d[8:0]), 32'h12);
		wr(utr_pkg::CTRL_OFS, 32'h40);
		repeat (40) @(posedge aclk);
		chk(32'(tx_pin), 32'h0);
		wr(utr_pkg::CTRL_OFS, 32'h0);
		poll(32'h2);
		chk(32'(i_utr_partner.seen[3]), 32'h0);
		chk(32'(tx_pin), 32'h1);
		stop_test();
	end
endmodule
